// File: verilog/rtis_top.sv
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module rtis_top #(
	parameter int BAUD_RUN_CYC = rtis_pkg::CLK_HZ / rtis_pkg::BAUD_RUN,
	parameter int BAUD_HI_CYC = rtis_pkg::CLK_HZ / rtis_pkg::BAUD_TEST_HI,
	parameter int BAUD_LO_CYC = rtis_pkg::CLK_HZ / rtis_pkg::BAUD_TEST_LO,
	parameter int TICK_CYC = rtis_pkg::CLK_HZ / 1000 * rtis_pkg::TICK_MS,
	parameter int CHARGE_DELAY_CYC = rtis_pkg::CLK_HZ / 1_000_000 * rtis_pkg::CHARGE_DELAY_US,
	parameter int PRF_SHORT_CYC = rtis_pkg::CLK_HZ / rtis_pkg::PRF_SHORT_HZ,
	parameter int PRF_MEDIUM_CYC = rtis_pkg::CLK_HZ / rtis_pkg::PRF_MEDIUM_HZ,
	parameter int PRF_LONG_CYC = rtis_pkg::CLK_HZ / rtis_pkg::PRF_LONG_HZ,
	parameter int SPARK_INHIBIT_TICKS = rtis_pkg::SPARK_INHIBIT_MS / rtis_pkg::TICK_MS,
	parameter int WARMUP_TICKS = rtis_pkg::WARMUP_S * 1000 / rtis_pkg::TICK_MS,
	parameter int ROT_TIMEOUT_TICKS = rtis_pkg::ROT_TIMEOUT_MS / rtis_pkg::TICK_MS,
	parameter int ACT_TIMEOUT_TICKS = rtis_pkg::ACT_TIMEOUT_MS / rtis_pkg::TICK_MS
) (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic DISPLAY_TO_TRANSCEIVER_SERIAL,
	output logic TRANSCEIVER_TO_DISPLAY_SERIAL,
	input wire logic SUPPLY_TEST_STRAP,
	output logic SUPPLY_START_DRIVE,
	output logic ANTENNA_DRIVE_ENABLE_N,
	input wire logic BEARING_PULSE,
	input wire logic HEADING_MARKER,
	output logic MODULATOR_TRIGGER,
	output logic CHARGE_TRIGGER,
	output logic [1:0] PULSE_WIDTH_SELECT,
	input wire logic MAGNETRON_FIRED_SAMPLE,
	output logic TRANSMIT_TIMING_PULSE,
	input wire logic SPARK_GAP_DETECT,
	input wire logic [7:0] DROPOUT_TIMER_LEVEL,
	input wire logic [7:0] MODULATOR_SUPPLY_LEVEL,
	input wire logic [7:0] MAGNETRON_CURRENT_LEVEL
);
	// ==========================================================
	// Elaboration checks.
	if (BAUD_RUN_CYC < 4 || BAUD_HI_CYC < 4 || BAUD_LO_CYC < 4 || TICK_CYC < 1) begin : g_chk_a
		$error("Baud or tick period too short.");
	end
	if (PRF_SHORT_CYC <= CHARGE_DELAY_CYC || PRF_LONG_CYC <= CHARGE_DELAY_CYC ||
		PRF_MEDIUM_CYC <= CHARGE_DELAY_CYC) begin : g_chk_b
		$error("Repetition period must exceed the charge delay.");
	end

	// Bit period for the selected link rate; used by both serial directions.
	function automatic logic [31:0] baud_cycles(input logic [1:0] sel);
		case (sel)
			2'b01: baud_cycles = 32'(BAUD_HI_CYC);
			2'b10: baud_cycles = 32'(BAUD_LO_CYC);
			default: baud_cycles = 32'(BAUD_RUN_CYC);
		endcase
	endfunction

	// ==========================================================
	// Edge detection and millisecond tick.
	logic bearing_q, heading_q, sample_q, spark_q, serial_q;
	logic [31:0] tick_cnt;
	logic tick;
	wire bearing_rise = BEARING_PULSE && !bearing_q;
	wire heading_rise = HEADING_MARKER && !heading_q;
	wire sample_rise = MAGNETRON_FIRED_SAMPLE && !sample_q;
	wire spark_rise = SPARK_GAP_DETECT && !spark_q;
	wire serial_fall = !DISPLAY_TO_TRANSCEIVER_SERIAL && serial_q;
	wire serial_edge = DISPLAY_TO_TRANSCEIVER_SERIAL != serial_q;

	// Previous input levels for edge detectors.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			bearing_q <= 1'b0;
			heading_q <= 1'b0;
			sample_q <= 1'b0;
			spark_q <= 1'b0;
			serial_q <= 1'b1;
		end else begin
			bearing_q <= BEARING_PULSE;
			heading_q <= HEADING_MARKER;
			sample_q <= MAGNETRON_FIRED_SAMPLE;
			spark_q <= SPARK_GAP_DETECT;
			serial_q <= DISPLAY_TO_TRANSCEIVER_SERIAL;
		end
	end

	// Divider giving a one-cycle enable each millisecond.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b0;
		end else begin
			tick <= tick_cnt == 32'(TICK_CYC - 1);
			tick_cnt <= (tick_cnt == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : tick_cnt + 32'h1;
		end
	end

	// ==========================================================
	// Register bus slave.
	logic [31:0] control;
	logic [7:0] dropout_thresh;
	logic [7:0] rx_errors;
	logic [7:0] supply_meas, current_meas;
	rtis_pkg::rtis_flags_t flags;
	logic xmit_flag, spark_flag, warm_flag, rot_flag, ant_flag;
	// Status flags are gathered here; each one is owned by a single process.
	assign flags = {xmit_flag, spark_flag, warm_flag, rot_flag, ant_flag};
	rtis_pkg::rtis_state_t state;
	wire [1:0] baud_sel = control[rtis_pkg::CTRL_BAUD_LSB +: 2];
	wire test_mode = control[rtis_pkg::CTRL_TEST_BIT];

	// One wait cycle per access; write lands at the edge where waitrequest is low.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h0000_0000;
			control <= rtis_pkg::CONTROL_RST;
			dropout_thresh <= rtis_pkg::DROPOUT_THRESH_RST;
		end else begin
			AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
			if (AVS_READ && AVS_WAITREQUEST) begin
				case (AVS_ADDRESS)
					rtis_pkg::REG_CONTROL: AVS_READDATA <= {29'h0, control[2:0]};
					rtis_pkg::REG_DROPOUT_THRESH: AVS_READDATA <= {24'h0, dropout_thresh};
					rtis_pkg::REG_STATUS: AVS_READDATA <= {25'h0, state, flags};
					rtis_pkg::REG_MEASURE: AVS_READDATA <= {16'h0, current_meas, supply_meas};
					rtis_pkg::REG_RX_ERRORS: AVS_READDATA <= {24'h0, rx_errors};
					default: AVS_READDATA <= 32'h0000_0000;
				endcase
			end
			if (AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]) begin
				case (AVS_ADDRESS)
					rtis_pkg::REG_CONTROL: control <= {29'h0, AVS_WRITEDATA[2:0]};
					rtis_pkg::REG_DROPOUT_THRESH: dropout_thresh <= AVS_WRITEDATA[7:0];
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// Supply start from display line activity.
	logic [31:0] act_cnt;

	// Any line transition rearms the activity window.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			act_cnt <= 32'h0000_0000;
			SUPPLY_START_DRIVE <= 1'b0;
		end else begin
			if (serial_edge) begin
				act_cnt <= 32'(ACT_TIMEOUT_TICKS);
			end else if (tick && act_cnt != 32'h0) begin
				act_cnt <= act_cnt - 32'h1;
			end
			SUPPLY_START_DRIVE <= act_cnt != 32'h0 || serial_edge || SUPPLY_TEST_STRAP;
		end
	end

	// ==========================================================
	// Receiver for display commands, 8 data, even parity, 1 stop.
	logic rx_busy;
	logic [3:0] rx_bit;
	logic [31:0] rx_cnt;
	logic [8:0] rx_shift;
	logic transmit_cmd;
	rtis_pkg::rtis_plen_t plen;

	// Samples each bit at its centre; a good byte updates the command.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rx_busy <= 1'b0;
			rx_bit <= 4'h0;
			rx_cnt <= 32'h0000_0000;
			rx_shift <= 9'h000;
			transmit_cmd <= 1'b0;
			plen <= rtis_pkg::RTIS_PLEN_SHORT;
			rx_errors <= 8'h00;
		end else begin
			if (!rx_busy) begin
				if (serial_fall) begin
					rx_busy <= 1'b1;
					rx_bit <= 4'h0;
					rx_cnt <= baud_cycles(baud_sel) >> 1;
				end
			end else if (rx_cnt != 32'h0) begin
				rx_cnt <= rx_cnt - 32'h1;
			end else begin
				rx_cnt <= baud_cycles(baud_sel) - 32'h1;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0 && DISPLAY_TO_TRANSCEIVER_SERIAL) begin
					rx_busy <= 1'b0;
				end else if (rx_bit >= 4'h1 && rx_bit <= 4'h9) begin
					rx_shift <= {DISPLAY_TO_TRANSCEIVER_SERIAL, rx_shift[8:1]};
				end else if (rx_bit == 4'hA) begin
					rx_busy <= 1'b0;
					if (DISPLAY_TO_TRANSCEIVER_SERIAL && !(^rx_shift)) begin
						transmit_cmd <= rx_shift[rtis_pkg::CMD_TX_BIT];
						if (rx_shift[rtis_pkg::CMD_PLEN_LSB +: 2] != 2'b11) begin
							plen <= rtis_pkg::rtis_plen_t'(rx_shift[rtis_pkg::CMD_PLEN_LSB +: 2]);
						end
					end else if (rx_errors != 8'hFF) begin
						rx_errors <= rx_errors + 8'h1;
					end
				end
			end
			if (spark_rise) begin
				transmit_cmd <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Interlocks: warm-up, spark gap, rotation.
	logic sampled;
	logic [31:0] warm_cnt, spark_cnt, rot_cnt;

	// Dropout level is caught once on the first edge after reset release.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sampled <= 1'b0;
			warm_cnt <= 32'h0000_0000;
			spark_cnt <= 32'h0000_0000;
			rot_cnt <= 32'h0000_0000;
			warm_flag <= 1'b0;
			rot_flag <= 1'b0;
		end else begin
			sampled <= 1'b1;
			if (!sampled) begin
				warm_cnt <= (DROPOUT_TIMER_LEVEL < dropout_thresh) ? 32'(WARMUP_TICKS) : 32'h0;
			end else if (tick && warm_cnt != 32'h0) begin
				warm_cnt <= warm_cnt - 32'h1;
			end
			warm_flag <= !sampled || warm_cnt != 32'h0;
			if (spark_rise) begin
				spark_cnt <= 32'(SPARK_INHIBIT_TICKS);
			end else if (tick && spark_cnt != 32'h0) begin
				spark_cnt <= spark_cnt - 32'h1;
			end
			if (bearing_rise) begin
				rot_cnt <= 32'(ROT_TIMEOUT_TICKS);
			end else if (tick && rot_cnt != 32'h0) begin
				rot_cnt <= rot_cnt - 32'h1;
			end
			rot_flag <= bearing_rise || rot_cnt != 32'h0;
		end
	end

	wire transmit_ok = state == rtis_pkg::RTIS_ST_TRANSMIT && spark_cnt == 32'h0 &&
		!flags.warmup_inhibit && (flags.rotating || test_mode);

	// ==========================================================
	// Transmit and standby sequencer.
	logic [12:0] rev_bearings;
	logic [1:0] rev_markers;
	rtis_pkg::rtis_state_t next_state;
	wire rev_done = (bearing_rise && rev_bearings == 13'(rtis_pkg::REV_BEARINGS - 1)) ||
		(heading_rise && rev_markers == 2'd1);

	// Next state of the sequencer.
	always_comb begin
		next_state = state;
		case (state)
			rtis_pkg::RTIS_ST_STANDBY: begin
				if (transmit_cmd && spark_cnt == 32'h0 && !flags.warmup_inhibit) begin
					next_state = rtis_pkg::RTIS_ST_SPINUP;
				end
			end
			rtis_pkg::RTIS_ST_SPINUP: begin
				if (!transmit_cmd || spark_rise) begin
					next_state = rtis_pkg::RTIS_ST_SPINDOWN;
				end else if (rev_done) begin
					next_state = rtis_pkg::RTIS_ST_TRANSMIT;
				end
			end
			rtis_pkg::RTIS_ST_TRANSMIT: begin
				if (!transmit_cmd || spark_rise) begin
					next_state = rtis_pkg::RTIS_ST_SPINDOWN;
				end
			end
			rtis_pkg::RTIS_ST_SPINDOWN: begin
				if (rev_done) begin
					next_state = rtis_pkg::RTIS_ST_STANDBY;
				end
			end
			default: next_state = rtis_pkg::RTIS_ST_STANDBY;
		endcase
	end

	// State register and revolution counting restarted on each state change.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= rtis_pkg::RTIS_ST_STANDBY;
			rev_bearings <= 13'h0000;
			rev_markers <= 2'd0;
			ANTENNA_DRIVE_ENABLE_N <= 1'b1;
			ant_flag <= 1'b0;
			PULSE_WIDTH_SELECT <= 2'b00;
		end else begin
			state <= next_state;
			if (next_state != state) begin
				rev_bearings <= 13'h0000;
				rev_markers <= 2'd0;
			end else begin
				if (bearing_rise) begin
					rev_bearings <= rev_bearings + 13'h1;
				end
				if (heading_rise && rev_markers != 2'd2) begin
					rev_markers <= rev_markers + 2'd1;
				end
			end
			ANTENNA_DRIVE_ENABLE_N <= next_state == rtis_pkg::RTIS_ST_STANDBY;
			ant_flag <= next_state != rtis_pkg::RTIS_ST_STANDBY;
			PULSE_WIDTH_SELECT <= plen;
		end
	end

	// ==========================================================
	// Repetition rate, modulator and charge triggers, display timing pulse.
	logic [31:0] prf_cnt, chg_dly;
	logic chg_pending;
	logic [11:0] mod_w, chg_w, tim_w;
	logic fire_armed;
	wire fire = prf_cnt == 32'h0;

	// Free-running repetition timer; charge follows each firing slot.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			prf_cnt <= 32'h0000_0000;
			chg_dly <= 32'h0000_0000;
			chg_pending <= 1'b0;
			mod_w <= 12'h000;
			chg_w <= 12'h000;
			MODULATOR_TRIGGER <= 1'b0;
			CHARGE_TRIGGER <= 1'b0;
		end else begin
			if (fire) begin
				case (plen)
					rtis_pkg::RTIS_PLEN_MEDIUM: prf_cnt <= 32'(PRF_MEDIUM_CYC - 1);
					rtis_pkg::RTIS_PLEN_LONG: prf_cnt <= 32'(PRF_LONG_CYC - 1);
					default: prf_cnt <= 32'(PRF_SHORT_CYC - 1);
				endcase
				chg_pending <= 1'b1;
				chg_dly <= 32'(CHARGE_DELAY_CYC - 1);
				if (transmit_ok) begin
					mod_w <= 12'(rtis_pkg::TRIG_WIDTH_CYC);
				end
			end else begin
				prf_cnt <= prf_cnt - 32'h1;
				if (chg_pending && chg_dly != 32'h0) begin
					chg_dly <= chg_dly - 32'h1;
				end else if (chg_pending) begin
					chg_pending <= 1'b0;
					chg_w <= 12'(rtis_pkg::TRIG_WIDTH_CYC);
				end
				if (mod_w != 12'h0) begin
					mod_w <= mod_w - 12'h1;
				end
			end
			if (chg_w != 12'h0 && !(chg_pending && chg_dly == 32'h0 && !fire)) begin
				chg_w <= chg_w - 12'h1;
			end
			MODULATOR_TRIGGER <= mod_w != 12'h0;
			CHARGE_TRIGGER <= chg_w != 12'h0;
		end
	end

	// Timing pulse starts on the fired sample when transmitting, else on the firing slot.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tim_w <= 12'h000;
			fire_armed <= 1'b0;
			TRANSMIT_TIMING_PULSE <= 1'b0;
		end else begin
			if (fire) begin
				fire_armed <= transmit_ok;
			end
			if (fire && !transmit_ok) begin
				tim_w <= 12'(rtis_pkg::TIMING_PULSE_CYC);
			end else if (sample_rise && fire_armed) begin
				tim_w <= 12'(rtis_pkg::TIMING_PULSE_CYC);
			end else if (tim_w != 12'h0) begin
				tim_w <= tim_w - 12'h1;
			end
			TRANSMIT_TIMING_PULSE <= tim_w != 12'h0;
		end
	end

	// Measurements; magnetron current is only taken while transmitting.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			supply_meas <= 8'h00;
			current_meas <= 8'h00;
			xmit_flag <= 1'b0;
		end else begin
			supply_meas <= MODULATOR_SUPPLY_LEVEL;
			if (transmit_ok) begin
				current_meas <= MAGNETRON_CURRENT_LEVEL;
			end
			xmit_flag <= transmit_ok;
		end
	end

	// ==========================================================
	// Status byte transmitter, one byte per bearing pulse.
	logic heading_bit;
	logic [1:0] sel;
	logic tx_pending, tx_busy;
	logic [3:0] tx_bit;
	logic [31:0] tx_cnt;
	logic [10:0] tx_shift;
	logic [7:0] status_byte;

	// Status byte content chosen by a rotating selector.
	always_comb begin
		status_byte = 8'h00;
		status_byte[rtis_pkg::STAT_HDG_BIT] = heading_bit;
		status_byte[rtis_pkg::STAT_SEL_LSB +: 2] = sel;
		case (sel)
			2'b01: status_byte[4:0] = supply_meas[7:3];
			2'b11: status_byte[4:0] = current_meas[7:3];
			default: status_byte[4:0] = flags;
		endcase
	end

	// Heading toggle, error queue and the serial shifter.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			heading_bit <= 1'b0;
			sel <= 2'b00;
			tx_pending <= 1'b0;
			tx_busy <= 1'b0;
			tx_bit <= 4'h0;
			tx_cnt <= 32'h0000_0000;
			tx_shift <= 11'h7FF;
			spark_flag <= 1'b0;
			TRANSCEIVER_TO_DISPLAY_SERIAL <= 1'b1;
		end else begin
			if (heading_rise) begin
				heading_bit <= !heading_bit;
			end
			if (bearing_rise) begin
				tx_pending <= 1'b1;
			end
			if (!tx_busy && tx_pending && !bearing_rise) begin
				tx_pending <= 1'b0;
				tx_busy <= 1'b1;
				tx_bit <= 4'h0;
				tx_cnt <= baud_cycles(baud_sel) - 32'h1;
				tx_shift <= {1'b1, ^status_byte, status_byte, 1'b0};
				sel <= sel + 2'b01;
			end else if (tx_busy) begin
				if (tx_cnt != 32'h0) begin
					tx_cnt <= tx_cnt - 32'h1;
				end else begin
					tx_cnt <= baud_cycles(baud_sel) - 32'h1;
					tx_shift <= {1'b1, tx_shift[10:1]};
					tx_bit <= tx_bit + 4'h1;
					tx_busy <= tx_bit != 4'hA;
				end
			end
			if (spark_rise) begin
				spark_flag <= 1'b1;
			end else if (!tx_busy && tx_pending && !bearing_rise && sel[0] == 1'b0) begin
				spark_flag <= 1'b0;
			end
			TRANSCEIVER_TO_DISPLAY_SERIAL <= tx_busy ? tx_shift[0] : 1'b1;
		end
	end
endmodule

// File: verilog/rtis_pkg.sv
package rtis_pkg;
	// ==========================================================
	// Timing figures in their own units.
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD_RUN = 76800;
	localparam int BAUD_TEST_HI = 38400;
	localparam int BAUD_TEST_LO = 19200;
	localparam int REV_BEARINGS = 4096;
	localparam int CHARGE_DELAY_US = 100;
	localparam int TRIG_WIDTH_NS = 1000;
	localparam int TIMING_PULSE_NS = 2500;
	localparam int TICK_MS = 1;
	localparam int SPARK_INHIBIT_MS = 1000;
	localparam int WARMUP_S = 180;
	localparam int ROT_TIMEOUT_MS = 100;
	localparam int ACT_TIMEOUT_MS = 10;
	localparam int PRF_SHORT_HZ = 1800;
	localparam int PRF_MEDIUM_HZ = 1800;
	localparam int PRF_LONG_HZ = 785;
	// Derived cycle counts of at most 4095 cycles.
	localparam int TRIG_WIDTH_CYC = (TRIG_WIDTH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int TIMING_PULSE_CYC = (TIMING_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// ==========================================================
	// Register map, byte addresses.
	localparam logic [7:0] REG_CONTROL = 8'h00;
	localparam logic [7:0] REG_DROPOUT_THRESH = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_MEASURE = 8'h0C;
	localparam logic [7:0] REG_RX_ERRORS = 8'h10;
	localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
	localparam logic [7:0] DROPOUT_THRESH_RST = 8'h80;
	localparam int CTRL_TEST_BIT = 0;
	localparam int CTRL_BAUD_LSB = 1;

	// ==========================================================
	// Incoming command byte and outgoing status byte layout.
	localparam int CMD_TX_BIT = 0;
	localparam int CMD_PLEN_LSB = 1;
	localparam int STAT_HDG_BIT = 7;
	localparam int STAT_SEL_LSB = 5;

	typedef enum logic [1:0] {
		RTIS_ST_STANDBY = 2'b00,
		RTIS_ST_SPINUP = 2'b01,
		RTIS_ST_TRANSMIT = 2'b10,
		RTIS_ST_SPINDOWN = 2'b11
	} rtis_state_t;

	typedef enum logic [1:0] {
		RTIS_PLEN_SHORT = 2'b00,
		RTIS_PLEN_MEDIUM = 2'b01,
		RTIS_PLEN_LONG = 2'b10
	} rtis_plen_t;

	typedef struct packed {
		logic transmitting;
		logic spark_error;
		logic warmup_inhibit;
		logic rotating;
		logic antenna_enabled;
	} rtis_flags_t;
endpackage

// File: verif/rtis_checker.sv
`timescale 1ns/1ps
// ====
// Port checks of rtis_top: triggers, antenna, supply start, width select and bus.
module rtis_checker #(
	parameter int CHARGE_DELAY_CYC = 200
) (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic AVS_WAITREQUEST,
	input wire logic DISPLAY_TO_TRANSCEIVER_SERIAL,
	input wire logic SUPPLY_TEST_STRAP,
	input wire logic SUPPLY_START_DRIVE,
	input wire logic ANTENNA_DRIVE_ENABLE_N,
	input wire logic MODULATOR_TRIGGER,
	input wire logic CHARGE_TRIGGER,
	input wire logic [1:0] PULSE_WIDTH_SELECT,
	input wire logic TRANSMIT_TIMING_PULSE
);
	localparam int D_LO = CHARGE_DELAY_CYC - 1;
	localparam int D_HI = CHARGE_DELAY_CYC + 1;
	logic [8:0] mod_run, chg_run, tim_run;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	// Length of the present high run of each pulse output.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mod_run <= 9'h000;
			chg_run <= 9'h000;
			tim_run <= 9'h000;
		end else begin
			mod_run <= MODULATOR_TRIGGER ? mod_run + 9'h001 : 9'h000;
			chg_run <= CHARGE_TRIGGER ? chg_run + 9'h001 : 9'h000;
			tim_run <= TRANSMIT_TIMING_PULSE ? tim_run + 9'h001 : 9'h000;
		end
	end
	property p_chg_delay;
		$rose(MODULATOR_TRIGGER) |-> ##[D_LO:D_HI] $rose(CHARGE_TRIGGER);
	endproperty
	a_chg_delay: assert property (p_chg_delay) else $error("charge delay wrong");
	property p_mod_width; $fell(MODULATOR_TRIGGER) |-> mod_run == 9'h064; endproperty
	a_mod_width: assert property (p_mod_width) else $error("modulator width wrong");
	property p_chg_width; $fell(CHARGE_TRIGGER) |-> chg_run == 9'h064; endproperty
	a_chg_width: assert property (p_chg_width) else $error("charge width wrong");
	property p_tim_width; $fell(TRANSMIT_TIMING_PULSE) |-> tim_run == 9'h0FA; endproperty
	a_tim_width: assert property (p_tim_width) else $error("timing width wrong");
	property p_mod_ant; MODULATOR_TRIGGER |-> !ANTENNA_DRIVE_ENABLE_N; endproperty
	a_mod_ant: assert property (p_mod_ant) else $error("firing without antenna");
	property p_strap; SUPPLY_TEST_STRAP |=> SUPPLY_START_DRIVE; endproperty
	a_strap: assert property (p_strap) else $error("strap ignored");
	property p_act; $changed(DISPLAY_TO_TRANSCEIVER_SERIAL) |-> ##[1:2] SUPPLY_START_DRIVE; endproperty
	a_act: assert property (p_act) else $error("supply off with activity");
	property p_pws; PULSE_WIDTH_SELECT != 2'b11; endproperty
	a_pws: assert property (p_pws) else $error("bad width select");
	property p_wait; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
endmodule
bind rtis_top rtis_checker #(.CHARGE_DELAY_CYC(CHARGE_DELAY_CYC)) u_chk (.SYS_CLK, .ARST_N,
	.AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .DISPLAY_TO_TRANSCEIVER_SERIAL, .SUPPLY_TEST_STRAP,
	.SUPPLY_START_DRIVE, .ANTENNA_DRIVE_ENABLE_N, .MODULATOR_TRIGGER, .CHARGE_TRIGGER,
	.PULSE_WIDTH_SELECT, .TRANSMIT_TIMING_PULSE);

// File: verif/rtis_display_model.sv
`timescale 1ns/1ps
// ====
// Display unit end of both serial links.
module rtis_display_model #(
	parameter int BAUD_CYC = 16
) (
	input wire logic clk,
	input wire logic rx_line,
	output logic tx_line
);
	logic [7:0] last;
	int rx_count, bad_count;
	// Sends one command frame, even parity, idle high after.
	task automatic send(input logic [7:0] b);
		logic [10:0] f;
		f = {1'b1, ^b, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			tx_line <= f[i];
			repeat (BAUD_CYC) @(posedge clk);
		end
	endtask
	// Receives status frames and checks framing and parity.
	initial begin
		logic [10:0] f;
		tx_line = 1'b1;
		rx_count = 0;
		bad_count = 0;
		last = 8'h00;
		forever begin
			@(negedge rx_line);
			repeat (BAUD_CYC / 2) @(posedge clk);
			for (int i = 0; i < 11; i++) begin
				f[i] = rx_line;
				if (i < 10) repeat (BAUD_CYC) @(posedge clk);
			end
			last = f[8:1];
			if (!f[0] && f[10] && !(^f[9:1])) rx_count++;
			else bad_count++;
		end
	end
endmodule

// File: verif/rtis_top_tb.sv
`timescale 1ns/1ps
module rtis_top_tb;
	localparam int BC = 16;
	logic sys_clk, arst_n, rd, wr, wait_req, du_ser, tx_ser, strap, supply, ant_n;
	logic bear, hdg, mod_trig, chg_trig, mag, ttp, spark, h0, bear_on;
	logic [1:0] pws;
	logic [7:0] addr, cur, drop, sup;
	logic [3:0] be;
	logic [31:0] wdata, rdata, q;
	int fails, total_checks, mod_n, chg_n, bear_n, m;
	// Only the figures that would make the run too long are shortened.
	rtis_top #(.TICK_CYC(10), .CHARGE_DELAY_CYC(200), .PRF_SHORT_CYC(400), .PRF_LONG_CYC(400),
		.BAUD_RUN_CYC(BC)) u_dut (
		.SYS_CLK(sys_clk), .ARST_N(arst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wait_req), .DISPLAY_TO_TRANSCEIVER_SERIAL(du_ser),
		.TRANSCEIVER_TO_DISPLAY_SERIAL(tx_ser), .SUPPLY_TEST_STRAP(strap),
		.SUPPLY_START_DRIVE(supply), .ANTENNA_DRIVE_ENABLE_N(ant_n), .BEARING_PULSE(bear),
		.HEADING_MARKER(hdg), .MODULATOR_TRIGGER(mod_trig), .CHARGE_TRIGGER(chg_trig),
		.PULSE_WIDTH_SELECT(pws), .MAGNETRON_FIRED_SAMPLE(mag), .TRANSMIT_TIMING_PULSE(ttp),
		.SPARK_GAP_DETECT(spark), .DROPOUT_TIMER_LEVEL(drop), .MODULATOR_SUPPLY_LEVEL(sup),
		.MAGNETRON_CURRENT_LEVEL(cur));
	rtis_display_model u_disp (.clk(sys_clk), .rx_line(tx_ser), .tx_line(du_ser));
	// ====
	// Shared tasks.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus access, held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		do @(posedge sys_clk); while (wait_req !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		check(q, e);
	endtask
	task automatic hdg_pulse();
		hdg <= 1'b1;
		repeat (4) @(posedge sys_clk);
		hdg <= 1'b0;
		repeat (600) @(posedge sys_clk);
	endtask
	task automatic finish_test();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Clock, watchdog, bearing source and trigger counters.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		fails++;
		finish_test();
	end
	always begin
		repeat (300) @(posedge sys_clk);
		if (bear_on) begin
			bear <= 1'b1;
			bear_n++;
			repeat (4) @(posedge sys_clk);
			bear <= 1'b0;
		end
	end
	always @(posedge mod_trig) mod_n++;
	always @(posedge chg_trig) chg_n++;
	// ====
	// Test sequence.
	initial begin
		{arst_n, rd, wr, strap, hdg, mag, spark, bear, bear_on} = 9'h000;
		{addr, cur, wdata} = {8'h00, 8'h3C, 32'h0000_0000};
		{be, drop, sup} = {4'hF, 8'hFF, 8'hA5};
		{fails, total_checks, mod_n, chg_n, bear_n} = '0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		rchk(rtis_pkg::REG_CONTROL, rtis_pkg::CONTROL_RST);
		rchk(rtis_pkg::REG_DROPOUT_THRESH, 32'(rtis_pkg::DROPOUT_THRESH_RST));
		bus(1'b1, 8'h14, 32'hFFFF_FFFF);
		rchk(8'h14, 32'h0000_0000);
		bus(1'b1, rtis_pkg::REG_CONTROL, 32'hFFFF_FFF6);
		rchk(rtis_pkg::REG_CONTROL, 32'h0000_0006);
		be <= 4'h0;
		bus(1'b1, rtis_pkg::REG_CONTROL, 32'h0000_0001);
		be <= 4'hF;
		rchk(rtis_pkg::REG_CONTROL, 32'h0000_0006);
		check(32'(ant_n), 32'h1);
		check(32'(supply), 32'h0);
		strap <= 1'b1;
		repeat (3) @(posedge sys_clk);
		check(32'(supply), 32'h1);
		strap <= 1'b0;
		u_disp.send(8'h00);
		check(32'(supply), 32'h1);
		repeat (200) @(posedge sys_clk);
		check(32'(supply), 32'h0);
		// Transmit request: antenna first, firing after one revolution.
		bear_on <= 1'b1;
		u_disp.send(8'h05);
		repeat (1000) @(posedge sys_clk);
		check(32'(ant_n), 32'h0);
		check(32'(pws), 32'h2);
		check(mod_n, 0);
		check(32'(chg_n > 0), 32'h1);
		bus(1'b0, rtis_pkg::REG_STATUS, 32'h0000_0000);
		check(32'(q[6:5]), 32'h1);
		h0 = u_disp.last[7];
		hdg_pulse();
		check(32'(u_disp.last[7]), 32'(!h0));
		hdg_pulse();
		@(posedge mod_trig);
		@(posedge sys_clk);
		check(32'(ttp), 32'h0);
		mag <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check(32'(ttp), 32'h1);
		mag <= 1'b0;
		rchk(rtis_pkg::REG_MEASURE, 32'h0000_3CA5);
		// Standby stops firing at once; the antenna stops a revolution later.
		u_disp.send(8'h04);
		m = mod_n;
		{cur, sup} <= {8'h11, 8'h5A};
		repeat (1000) @(posedge sys_clk);
		check(mod_n, m);
		check(32'(ant_n), 32'h0);
		rchk(rtis_pkg::REG_MEASURE, 32'h0000_3C5A);
		hdg_pulse();
		hdg_pulse();
		check(32'(ant_n), 32'h1);
		bear_on <= 1'b0;
		repeat (600) @(posedge sys_clk);
		check(u_disp.rx_count, bear_n);
		check(u_disp.bad_count, 0);
		// A spark inhibits transmit and flags an error.
		spark <= 1'b1;
		u_disp.send(8'h01);
		check(32'(ant_n), 32'h1);
		bus(1'b0, rtis_pkg::REG_STATUS, 32'h0000_0000);
		check(32'(q[3]), 32'h1);
		// A reset after a long outage starts the warm-up inhibit.
		{spark, drop} <= {1'b0, 8'h10};
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		bus(1'b0, rtis_pkg::REG_STATUS, 32'h0000_0000);
		check(q, 32'h0000_0004);
		u_disp.send(8'h01);
		check(32'(ant_n), 32'h1);
		finish_test();
	end
endmodule
